// ===== rtl/reset_seq_pkg.sv
// Purpose: shared constants for the reset source sequencer
// Assumes: 32-bit APB register access, one word per register
// Notes: watchdog control/status bit layout and reset values live here
package reset_seq_pkg;
	// register byte addresses
	localparam logic [11:0] ADDR_WDCS = 12'h000;
	localparam logic [11:0] ADDR_CTRL = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [11:0] ADDR_PORT = 12'h00c;
	// watchdog_control_status fields
	localparam int BIT_POR = 6;
	localparam int BIT_PFI = 4;
	localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 3;
	localparam int BIT_WATCHDOG_RESET_FLAG = 2;
	localparam int BIT_EWT = 1;
	localparam logic [7:0] WDCS_POR_VAL = 8'h40;
	localparam logic [7:0] WDCS_RW_MASK = 8'h5e;
	// control register fields
	localparam int CTRL_DIV_LSB = 0;
	localparam int CTRL_WDCLR_BIT = 8;
	// clock divider select codes
	localparam logic [1:0] DIV_SEL_4 = 2'h1;
	localparam logic [1:0] DIV_SEL_64 = 2'h2;
	localparam logic [1:0] DIV_SEL_1024 = 2'h3;
	localparam logic [9:0] DIV_LAST_4 = 10'h003;
	localparam logic [9:0] DIV_LAST_64 = 10'h03f;
	localparam logic [9:0] DIV_LAST_1024 = 10'h3ff;
	// reset timing
	localparam logic [1:0] STRETCH_MC = 2'h2;
	localparam logic [1:0] WDT_HOLD_MC = 2'h2;
	localparam logic [9:0] WDT_RST_DLY_LAST = 10'h1ff;
	// reset values forced into core registers
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] TA_RESET = 8'hff;
	localparam logic [7:0] PORT_RESET = 8'hff;
	localparam int PORT_COUNT = 4;
	// dominant reset cause
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_POWER = 3'b001,
		ST_EXT = 3'b010,
		ST_WDT = 3'b011,
		ST_STRETCH = 3'b100
	} reset_state_type;
endpackage

// ===== rtl/reset_source_sequencer.sv
// Purpose: reset source sequencer with cause flags and watchdog reset
// Assumes: pclk is the core clock; inputs synchronous to pclk
// Notes: presetn acts as the first power-on reset
//
// Functional notes
// - reset pin sampled once per machine cycle, at its fourth clock state
// - internal reset applied synchronously; reset pin has no effect while clock stopped
// - device stays in reset while the reset pin stays high
// - after the pin is sampled low, reset lasts two more machine cycles
// - external reset sets no cause flag
// - supply loss enters reset; recovery runs power-on delay, sets power-on flag
// - watchdog counts continuously; software clear restarts it
// - timeout sets flag; enabled reset follows 512 clocks later unless cleared
// - watchdog reset is held two machine cycles
// - program counter forced to 0000h and held throughout reset
// - RAM untouched; stack pointer loaded with 07h
// - other special registers clear; timed-access register loads all ones
// - every port latch loads all ones
// - watchdog disabled after reset only when source was power-on
// - watchdog control and status register takes a source-dependent reset value
// - power-on flag set only by power-on reset
// - power-fail flag set on power fail, cleared by power-on reset
// - watchdog-reset flag set by watchdog reset, cleared by power-on
// - watchdog-reset enable cleared by power-on, kept by other resets
// - watchdog timeout flag set when timeout count is reached
// - one machine cycle is four clocks by default
// - any reset returns divider to divide-by-four
`timescale 1ns/1ps
module reset_source_sequencer
	import reset_seq_pkg::*;
#(
	parameter int WDT_INTERVAL = 131072,
	parameter int WDT_CNT_W = 18,
	parameter int POR_DELAY_MC = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// reset sources
	input wire logic reset_pin,
	input wire logic clock_run,
	input wire logic power_ok,
	input wire logic power_fail_warn,
	// core side
	output logic core_reset,
	output logic machine_tick,
	output logic [15:0] program_counter,
	output logic [7:0] stack_pointer,
	output logic [7:0] timed_access_reg,
	output logic [PORT_COUNT*8-1:0] port_latch
);

////////////////////////////////////////////////////////////////////////////////
// declarations
logic [9:0] div_cnt_r;
logic [9:0] div_last;
logic [1:0] div_sel_r;
logic mc_tick;
logic ext_seen_r;
logic [1:0] stretch_r;
logic [1:0] wdt_hold_r;
logic [7:0] por_cnt_r;
logic power_ok_r;
logic [7:0] wdcs_r;
logic [WDT_CNT_W-1:0] wdt_cnt_r;
logic wdt_timeout;
logic wdt_arm_r;
logic [9:0] wdt_dly_r;
logic wdt_fire;
logic wdt_clear;
reset_state_type state_r;
reset_state_type state_nxt;
logic apb_access;
logic apb_wr;
logic addr_ok;
logic [31:0] rdata_nxt;
logic [1:0] div_wr;

////////////////////////////////////////////////////////////////////////////////
// machine cycle divider
always_comb begin
	case (div_sel_r)
		DIV_SEL_64: div_last = DIV_LAST_64;
		DIV_SEL_1024: div_last = DIV_LAST_1024;
		default: div_last = DIV_LAST_4;
	endcase
end

// last clock of the machine cycle is the fourth clock state
assign mc_tick = clock_run && (div_cnt_r == div_last);

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		div_cnt_r <= 10'h000;
	end else if (clock_run) begin
		if (div_cnt_r >= div_last) begin
			div_cnt_r <= 10'h000;
		end else begin
			div_cnt_r <= div_cnt_r + 10'h001;
		end
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		machine_tick <= 1'b0;
	end else begin
		machine_tick <= mc_tick;
	end
end

// economy rate select; 64 and 1024 only entered from divide-by-four
assign div_wr = pwdata[CTRL_DIV_LSB +: 2];

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		div_sel_r <= DIV_SEL_4;
	end else if (core_reset) begin
		div_sel_r <= DIV_SEL_4;
	end else if (apb_wr && paddr == ADDR_CTRL) begin
		if (div_sel_r == DIV_SEL_4 || div_wr == DIV_SEL_4) begin
			div_sel_r <= div_wr;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// external reset pin
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ext_seen_r <= 1'b0;
	end else if (mc_tick) begin
		ext_seen_r <= reset_pin;
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		stretch_r <= 2'h0;
	end else if (ext_seen_r) begin
		stretch_r <= STRETCH_MC;
	end else if (mc_tick && stretch_r != 2'h0) begin
		stretch_r <= stretch_r - 2'h1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// power-on and power-fail
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		power_ok_r <= 1'b0;
	end else begin
		power_ok_r <= power_ok;
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		por_cnt_r <= 8'(POR_DELAY_MC);
	end else if (!power_ok) begin
		por_cnt_r <= 8'(POR_DELAY_MC);
	end else if (mc_tick && por_cnt_r != 8'h00) begin
		por_cnt_r <= por_cnt_r - 8'h01;
	end
end

////////////////////////////////////////////////////////////////////////////////
// watchdog
assign wdt_clear = apb_wr && paddr == ADDR_CTRL && pwdata[CTRL_WDCLR_BIT];
assign wdt_timeout = wdt_cnt_r == WDT_CNT_W'(WDT_INTERVAL - 1);
assign wdt_fire = wdt_arm_r && wdt_dly_r == WDT_RST_DLY_LAST && !wdt_clear;

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wdt_cnt_r <= '0;
	end else if (wdt_clear || wdt_timeout || core_reset) begin
		wdt_cnt_r <= '0;
	end else begin
		wdt_cnt_r <= wdt_cnt_r + WDT_CNT_W'(1);
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wdt_arm_r <= 1'b0;
		wdt_dly_r <= 10'h000;
	end else if (wdt_clear || core_reset || wdt_fire) begin
		wdt_arm_r <= 1'b0;
		wdt_dly_r <= 10'h000;
	end else if (wdt_timeout && wdcs_r[BIT_EWT] && !wdt_arm_r) begin
		wdt_arm_r <= 1'b1;
		wdt_dly_r <= 10'h000;
	end else if (wdt_arm_r) begin
		wdt_dly_r <= wdt_dly_r + 10'h001;
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wdt_hold_r <= 2'h0;
	end else if (wdt_fire) begin
		wdt_hold_r <= WDT_HOLD_MC;
	end else if (mc_tick && wdt_hold_r != 2'h0) begin
		wdt_hold_r <= wdt_hold_r - 2'h1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// reset state and combined internal reset
always_comb begin
	if (!power_ok || por_cnt_r != 8'h00) begin
		state_nxt = ST_POWER;
	end else if (ext_seen_r) begin
		state_nxt = ST_EXT;
	end else if (wdt_fire || wdt_hold_r != 2'h0) begin
		state_nxt = ST_WDT;
	end else if (stretch_r != 2'h0) begin
		state_nxt = ST_STRETCH;
	end else begin
		state_nxt = ST_RUN;
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		state_r <= ST_POWER;
		core_reset <= 1'b1;
	end else begin
		state_r <= state_nxt;
		core_reset <= state_nxt != ST_RUN;
	end
end

////////////////////////////////////////////////////////////////////////////////
// watchdog control and status register
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		wdcs_r <= WDCS_POR_VAL;
	end else if (!power_ok) begin
		wdcs_r <= WDCS_POR_VAL;
	end else begin
		if (apb_wr && paddr == ADDR_WDCS) begin
			wdcs_r <= pwdata[7:0] & WDCS_RW_MASK;
		end
		if (state_r == ST_EXT) begin
			wdcs_r[BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b0;
		end
		if (power_fail_warn) begin
			wdcs_r[BIT_PFI] <= 1'b1;
		end
		if (wdt_timeout) begin
			wdcs_r[BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b1;
		end
		if (wdt_fire) begin
			wdcs_r[BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b0;
			wdcs_r[BIT_WATCHDOG_RESET_FLAG] <= 1'b1;
		end
		if (!power_ok_r && power_ok) begin
			wdcs_r[BIT_POR] <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// core registers forced during reset
always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		program_counter <= PC_RESET;
	end else if (core_reset) begin
		program_counter <= PC_RESET;
	end else if (mc_tick) begin
		program_counter <= program_counter + 16'h0001;
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		stack_pointer <= SP_RESET;
		timed_access_reg <= TA_RESET;
	end else if (core_reset) begin
		stack_pointer <= SP_RESET;
		timed_access_reg <= TA_RESET;
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		port_latch <= {PORT_COUNT{PORT_RESET}};
	end else if (core_reset) begin
		port_latch <= {PORT_COUNT{PORT_RESET}};
	end else if (apb_wr && paddr == ADDR_PORT) begin
		port_latch <= pwdata[PORT_COUNT*8-1:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave: one wait state, answer registered
assign apb_access = psel && penable;
assign apb_wr = apb_access && pready && pwrite && addr_ok;
assign addr_ok = paddr == ADDR_WDCS || paddr == ADDR_CTRL ||
	paddr == ADDR_STAT || paddr == ADDR_PORT;

always_comb begin
	rdata_nxt = 32'h0000_0000;
	case (paddr)
		ADDR_WDCS: rdata_nxt[7:0] = wdcs_r;
		ADDR_CTRL: rdata_nxt[CTRL_DIV_LSB +: 2] = div_sel_r;
		ADDR_STAT: rdata_nxt = {27'h0, core_reset, 1'b0, state_r};
		ADDR_PORT: rdata_nxt[PORT_COUNT*8-1:0] = port_latch;
		default: rdata_nxt = 32'h0000_0000;
	endcase
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h0000_0000;
	end else if (apb_access && !pready) begin
		pready <= 1'b1;
		pslverr <= !addr_ok;
		prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
	end else begin
		pready <= 1'b0;
		pslverr <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// checks
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

chk_pin_sample: assert property ($changed(ext_seen_r) |-> $past(mc_tick))
	else $error("reset pin sampled outside fourth clock state");
chk_pin_hold: assert property (ext_seen_r |=> core_reset)
	else $error("reset released while pin sample high");
chk_stretch: assert property ($fell(ext_seen_r) |-> core_reset ##1 core_reset)
	else $error("reset not stretched after pin release");
chk_por_flag: assert property ($rose(power_ok) |=> wdcs_r[BIT_POR])
	else $error("power-on flag not set on recovery");
chk_wdt_delay: assert property (wdt_fire |-> $past(wdt_timeout, 512) && $past(wdcs_r[BIT_EWT], 512))
	else $error("watchdog reset not 512 clocks after timeout");
chk_wdt_hold: assert property (wdt_fire |=> core_reset [*4])
	else $error("watchdog reset held too short");
chk_pc_held: assert property (core_reset |=> program_counter == 16'h0000)
	else $error("program counter not held at zero");
chk_sp_ta: assert property (core_reset |=> stack_pointer == 8'h07 && timed_access_reg == 8'hff)
	else $error("stack pointer or timed access not reloaded");
chk_ports: assert property (core_reset |=> port_latch == {PORT_COUNT{8'hff}})
	else $error("port latches not set to ones");
chk_por_value: assert property (!power_ok |=> wdcs_r == 8'h40)
	else $error("power-on control value wrong");
chk_watchdog_reset_flag_set: assert property (wdt_fire |=> wdcs_r[BIT_WATCHDOG_RESET_FLAG] && !wdcs_r[BIT_WATCHDOG_TIMEOUT_FLAG])
	else $error("watchdog reset flag not set");
chk_div_reset: assert property (core_reset |=> div_sel_r == DIV_SEL_4)
	else $error("divider not forced to four");

cov_ext_reset: cover property ($fell(ext_seen_r) ##[1:16] !core_reset);
cov_wdt_reset: cover property (wdt_fire);
cov_power_cycle: cover property ($rose(power_ok) ##[1:200] !core_reset);
cov_economy: cover property (div_sel_r == DIV_SEL_64);

endmodule // reset_source_sequencer

// ===== tb/ext_reset_source.sv
// Purpose: outside reset source driving reset_pin
// Assumes: fire is a one-clock request from the bench
// Notes: pulse never shorter than two machine cycles at divide by four
`timescale 1ns/1ps
module ext_reset_source (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request
	input wire logic fire,
	input wire logic [7:0] len,
	// pin
	output logic reset_pin
);
	logic [7:0] left_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_r <= 8'h00;
		end else if (fire) begin
			left_r <= (len < 8'h08) ? 8'h08 : len;
		end else if (left_r != 8'h00) begin
			left_r <= left_r - 8'h01;
		end
	end
	assign reset_pin = (left_r != 8'h00);
endmodule // ext_reset_source

// ===== tb/reset_source_sequencer_bench.sv
// Purpose: self-checking bench for the reset source sequencer
// Assumes: short watchdog and power-on counts set below
// Notes: apb reads and writes go through one task
`timescale 1ns/1ps
module reset_source_sequencer_bench
	import reset_seq_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, port_latch;
	logic pready, pslverr, err, reset_pin, core_reset, machine_tick;
	logic clock_run = 1, power_ok = 1, power_fail_warn = 0, fire = 0;
	logic [7:0] len = 8'h10, stack_pointer, timed_access_reg;
	logic [15:0] program_counter;
	int failures = 0, n_tests = 0, clk_cnt = 0, t0, i, n;
	////////////////////////////////////////////////////////////////////
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) clk_cnt <= clk_cnt + 1;
	reset_source_sequencer #(.WDT_INTERVAL(64), .WDT_CNT_W(7), .POR_DELAY_MC(2)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reset_pin(reset_pin),
		.clock_run(clock_run), .power_ok(power_ok),
		.power_fail_warn(power_fail_warn), .core_reset(core_reset),
		.machine_tick(machine_tick), .program_counter(program_counter),
		.stack_pointer(stack_pointer), .timed_access_reg(timed_access_reg),
		.port_latch(port_latch));
	ext_reset_source src_u (.pclk(pclk), .presetn(presetn), .fire(fire),
		.len(len), .reset_pin(reset_pin));
	////////////////////////////////////////////////////////////////////
	task conclude;
		$display("counts failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (k == 20) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, pready, 1'b1);
			conclude();
		end
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0);
		chk(rd, exp);
	endtask
	task wait_rst(input logic v, input int lim);
		int k;
		for (k = 0; k < lim && core_reset !== v; k++) @(posedge pclk);
		if (k == lim) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, core_reset, v);
			conclude();
		end
	endtask
	task pulse_pin(input logic [7:0] l);
		@(posedge pclk);
		len <= l;
		fire <= 1;
		@(posedge pclk);
		fire <= 0;
	endtask
	////////////////////////////////////////////////////////////////////
	task t_por;
		chk(program_counter, 32'h0);
		chk(stack_pointer, 32'h07);
		chk(timed_access_reg, 32'hff);
		chk(port_latch, 32'hffffffff);
		rdchk(ADDR_WDCS, 32'h40);
		wait_rst(0, 200);
		n = 0;
		for (i = 0; i < 40; i++) begin
			@(posedge pclk);
			n += machine_tick;
		end
		chk(n, 10);
		chk(program_counter >= 16'h8 && program_counter <= 16'hc, 1);
		$display("por done");
	endtask
	task t_ext;
		apb(1, ADDR_WDCS, 32'h0);
		apb(1, ADDR_PORT, 32'h12345678);
		clock_run <= 0;
		pulse_pin(8'h10);
		repeat (20) @(posedge pclk);
		chk(core_reset, 0);
		clock_run <= 1;
		apb(1, ADDR_CTRL, {30'h0, DIV_SEL_64});
		pulse_pin(8'hc8);
		wait_rst(1, 200);
		@(posedge pclk);
		chk(program_counter, 32'h0);
		for (i = 0; i < 250 && reset_pin === 1'b1; i++) @(posedge pclk);
		chk(core_reset, 1);
		wait_rst(0, 20);
		chk(port_latch, 32'hffffffff);
		rdchk(ADDR_WDCS, 32'h0);
		apb(0, ADDR_CTRL, 32'h0);
		chk(rd[1:0], DIV_SEL_4);
		$display("ext done");
	endtask
	task t_wdt;
		apb(1, ADDR_WDCS, 32'h02);
		apb(1, ADDR_CTRL, 32'h101);
		t0 = clk_cnt;
		repeat (100) @(posedge pclk);
		rdchk(ADDR_WDCS, 32'h0a);
		wait_rst(1, 700);
		chk((clk_cnt - t0) >= 570 && (clk_cnt - t0) <= 590, 1);
		chk(stack_pointer, 32'h07);
		t0 = clk_cnt;
		wait_rst(0, 40);
		chk((clk_cnt - t0) >= 5 && (clk_cnt - t0) <= 16, 1);
		rdchk(ADDR_WDCS, 32'h06);
		$display("wdt done");
	endtask
	task t_wdclr;
		for (i = 0; i < 30; i++) begin
			apb(1, ADDR_CTRL, 32'h101);
			repeat (30) @(posedge pclk);
			chk(core_reset, 0);
		end
		apb(1, ADDR_WDCS, 32'h0);
		apb(1, 12'h010, 32'h5);
		chk(err, 1);
		rdchk(12'h010, 32'h0);
		chk(err, 1);
		$display("wdclr done");
	endtask
	task t_pfail;
		power_fail_warn <= 1;
		repeat (4) @(posedge pclk);
		power_fail_warn <= 0;
		apb(0, ADDR_WDCS, 32'h0);
		chk(rd & 32'h10, 32'h10);
		power_ok <= 0;
		repeat (10) @(posedge pclk);
		chk(core_reset, 1);
		power_ok <= 1;
		wait_rst(0, 200);
		rdchk(ADDR_WDCS, 32'h40);
		$display("pfail done");
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_por();
		t_ext();
		t_wdt();
		t_wdclr();
		t_pfail();
		conclude();
	end
endmodule // reset_source_sequencer_bench
